/* File: core/fiap_ctrl.sv */
// Flash in-application read, erase and program controller with APB slave
`timescale 1ns/1ns
module fiap_ctrl #(
	parameter int OP_SHORT_CYC = fiap_pkg::FIAP_OP_SHORT_US * 1000 /
		fiap_pkg::FIAP_CLK_NS,
	parameter int OP_LONG_CYC = fiap_pkg::FIAP_OP_LONG_US * 1000 /
		fiap_pkg::FIAP_CLK_NS,
	parameter int UNLOCK_CYC = fiap_pkg::FIAP_UNLOCK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output fiap_pkg::fiap_flash_req_t flash_req,
	input wire logic [15:0] flash_rdata,
	output logic cpu_stall
);
	import fiap_pkg::*;

	typedef enum logic [1:0] {FIAP_IDLE, FIAP_READ, FIAP_OP} fiap_state_t;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	fiap_state_t state_q, state_d;
	logic [2:0] mode_q, mode_d;
	logic rden_q, rden_d, rreq_q, rreq_d, trig_q, trig_d;
	logic arm_q, arm_d, unlock_q, unlock_d, tsel_q, tsel_d;
	logic refused_q, refused_d, erase_op_q, erase_op_d;
	logic [FIAP_ADDR_W-1:0] addr_q, addr_d;
	logic [15:0] data_q, data_d;
	logic [7:0] dlow_q, dlow_d;
	logic [47:0] aux_q, aux_d;
	logic [FIAP_CNT_W-1:0] cnt_q, cnt_d;
	logic [FIAP_CNT_W-1:0] ucnt_q, ucnt_d;
	logic [FIAP_WIDX_W-1:0] widx_q, widx_d, pidx_q, pidx_d;
	logic [15:0] buf_q [FIAP_PAGE_WORDS];
	logic [FIAP_PAGE_WORDS-1:0] bvalid_q, bvalid_d;
	logic buf_we;
	logic [31:0] prdata_d;
	logic pslverr_d, pready_d, stall_d;
	fiap_flash_req_t req_d;
	logic wr_acc, rd_acc;

	assign wr_acc = psel && penable && pwrite && !pready;
	assign rd_acc = psel && penable && !pwrite && !pready;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		mode_d = mode_q;
		rden_d = rden_q;
		rreq_d = rreq_q;
		trig_d = trig_q;
		arm_d = arm_q;
		unlock_d = unlock_q;
		tsel_d = tsel_q;
		refused_d = refused_q;
		erase_op_d = erase_op_q;
		addr_d = addr_q;
		data_d = data_q;
		dlow_d = dlow_q;
		aux_d = aux_q;
		cnt_d = cnt_q;
		ucnt_d = ucnt_q;
		widx_d = widx_q;
		pidx_d = pidx_q;
		bvalid_d = bvalid_q;
		buf_we = 1'b0;
		prdata_d = '0;
		pslverr_d = 1'b0;
		pready_d = 1'b0;
		req_d = '0;
		// APB access completes in one wait cycle; held off while stalled
		if (psel && penable && !pready && state_q == FIAP_IDLE) begin
			pready_d = 1'b1;
		end
		if (wr_acc && state_q == FIAP_IDLE) begin
			unique case (paddr)
			FIAP_CTRL_OFS: begin
				mode_d = pwdata[FIAP_MODE_LSB +: 3];
				rden_d = pwdata[FIAP_READ_EN_POS];
				tsel_d = pwdata[FIAP_TSEL_POS];
				// Unlock flag may only be cleared by software
				if (!pwdata[FIAP_UNLOCK_POS]) begin
					unlock_d = 1'b0;
				end
				if (pwdata[FIAP_CLR_BUF_POS]) begin
					bvalid_d = '0;
					widx_d = '0;
				end
				if (pwdata[FIAP_ARM_POS] && !arm_q &&
						pwdata[FIAP_MODE_LSB +: 3] == FIAP_MODE_UNLOCK) begin
					arm_d = 1'b1;
					ucnt_d = FIAP_CNT_W'(UNLOCK_CYC);
					aux_d = '0;
				end
				if (pwdata[FIAP_READ_REQ_POS] && pwdata[FIAP_READ_EN_POS] &&
						pwdata[FIAP_MODE_LSB +: 3] == FIAP_MODE_READ) begin
					rreq_d = 1'b1;
					state_d = FIAP_READ;
					cnt_d = FIAP_CNT_W'(FIAP_READ_CYC - 1);
					req_d.rd = 1'b1;
					req_d.addr = addr_q;
				end else if (pwdata[FIAP_TRIG_POS] &&
						(pwdata[FIAP_MODE_LSB +: 3] == FIAP_MODE_PROG ||
						pwdata[FIAP_MODE_LSB +: 3] == FIAP_MODE_ERASE)) begin
					if (unlock_d) begin
						trig_d = 1'b1;
						state_d = FIAP_OP;
						refused_d = 1'b0;
						erase_op_d = pwdata[FIAP_MODE_LSB +: 3] == FIAP_MODE_ERASE;
						pidx_d = '0;
						cnt_d = pwdata[FIAP_TSEL_POS] ? FIAP_CNT_W'(OP_LONG_CYC)
							: FIAP_CNT_W'(OP_SHORT_CYC);
					end else begin
						refused_d = 1'b1;
					end
				end
			end
			FIAP_ADDR_LOW_OFS: begin
				addr_d[7:0] = pwdata[7:0];
				widx_d = pwdata[FIAP_WIDX_W-1:0];
			end
			FIAP_ADDR_HIGH_OFS: begin
				addr_d[FIAP_ADDR_W-1:8] = pwdata[FIAP_ADDR_W-9:0];
			end
			FIAP_DATA_LOW_OFS: begin
				dlow_d = pwdata[7:0];
			end
			FIAP_DATA_HIGH_OFS: begin
				// High byte completes a buffer word; index stops at page end
				buf_we = 1'b1;
				bvalid_d[widx_q] = 1'b1;
				if (widx_q != FIAP_WIDX_W'(FIAP_PAGE_WORDS - 1)) begin
					widx_d = widx_q + 1'b1;
				end
			end
			FIAP_AUX_LOW_OFS: begin
				if (arm_q) begin
					aux_d[47:24] = pwdata[23:0];
				end
			end
			FIAP_AUX_HIGH_OFS: begin
				if (arm_q) begin
					aux_d[23:0] = pwdata[23:0];
				end
			end
			default: begin
				pslverr_d = 1'b1;
			end
			endcase
		end else if (rd_acc && state_q == FIAP_IDLE) begin
			unique case (paddr)
			FIAP_CTRL_OFS: begin
				prdata_d[FIAP_MODE_LSB +: 3] = mode_q;
				prdata_d[FIAP_READ_EN_POS] = rden_q;
				prdata_d[FIAP_READ_REQ_POS] = rreq_q;
				prdata_d[FIAP_TRIG_POS] = trig_q;
				prdata_d[FIAP_ARM_POS] = arm_q;
				prdata_d[FIAP_UNLOCK_POS] = unlock_q;
				prdata_d[FIAP_TSEL_POS] = tsel_q;
			end
			FIAP_ADDR_LOW_OFS: prdata_d[7:0] = addr_q[7:0];
			FIAP_ADDR_HIGH_OFS: prdata_d[FIAP_ADDR_W-9:0] = addr_q[FIAP_ADDR_W-1:8];
			FIAP_DATA_LOW_OFS: prdata_d[7:0] = data_q[7:0];
			FIAP_DATA_HIGH_OFS: prdata_d[7:0] = data_q[15:8];
			FIAP_AUX_LOW_OFS: prdata_d[23:0] = aux_q[47:24];
			FIAP_AUX_HIGH_OFS: prdata_d[23:0] = aux_q[23:0];
			FIAP_STATUS_OFS: begin
				prdata_d[FIAP_STALL_POS] = cpu_stall;
				prdata_d[FIAP_REFUSED_POS] = refused_q;
			end
			default: pslverr_d = 1'b1;
			endcase
		end
		// Unlock timer: flag set only on exact pattern, arm drops regardless
		if (arm_q) begin
			if (ucnt_q == '0) begin
				arm_d = 1'b0;
				unlock_d = unlock_d || (aux_q == FIAP_UNLOCK_PAT);
			end else begin
				ucnt_d = ucnt_q - 1'b1;
			end
		end
		unique case (state_q)
		FIAP_IDLE: begin
		end
		FIAP_READ: begin
			// Data registers update with the clear of the request
			if (cnt_q == '0) begin
				data_d = flash_rdata;
				rreq_d = 1'b0;
				state_d = FIAP_IDLE;
			end else begin
				cnt_d = cnt_q - 1'b1;
			end
		end
		FIAP_OP: begin
			if (erase_op_q) begin
				// Single page erase command on first cycle
				req_d.erase = cnt_q == (tsel_q ? FIAP_CNT_W'(OP_LONG_CYC)
					: FIAP_CNT_W'(OP_SHORT_CYC));
				req_d.addr = {addr_q[FIAP_ADDR_W-1 -: FIAP_PAGE_W],
					FIAP_WIDX_W'(0)};
			end else if (pidx_q != FIAP_WIDX_W'(FIAP_PAGE_WORDS - 1) ||
					bvalid_q[pidx_q]) begin
				// Stream loaded buffer words into the page
				req_d.prog = bvalid_q[pidx_q];
				req_d.addr = {addr_q[FIAP_ADDR_W-1 -: FIAP_PAGE_W], pidx_q};
				req_d.wdata = buf_q[pidx_q];
				if (pidx_q != FIAP_WIDX_W'(FIAP_PAGE_WORDS - 1)) begin
					pidx_d = pidx_q + 1'b1;
				end else begin
					bvalid_d[pidx_q] = 1'b0;
				end
			end
			if (cnt_q == '0) begin
				trig_d = 1'b0;
				state_d = FIAP_IDLE;
			end else begin
				cnt_d = cnt_q - 1'b1;
			end
		end
		endcase
		stall_d = state_d != FIAP_IDLE;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= FIAP_IDLE;
			mode_q <= '0;
			rden_q <= 1'b0;
			rreq_q <= 1'b0;
			trig_q <= 1'b0;
			arm_q <= 1'b0;
			unlock_q <= 1'b0;
			tsel_q <= 1'b0;
			refused_q <= 1'b0;
			erase_op_q <= 1'b0;
			addr_q <= '0;
			data_q <= '0;
			dlow_q <= '0;
			aux_q <= '0;
			cnt_q <= '0;
			ucnt_q <= '0;
			widx_q <= '0;
			pidx_q <= '0;
			bvalid_q <= '0;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			flash_req <= '0;
			cpu_stall <= 1'b0;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
			rden_q <= rden_d;
			rreq_q <= rreq_d;
			trig_q <= trig_d;
			arm_q <= arm_d;
			unlock_q <= unlock_d;
			tsel_q <= tsel_d;
			refused_q <= refused_d;
			erase_op_q <= erase_op_d;
			addr_q <= addr_d;
			data_q <= data_d;
			dlow_q <= dlow_d;
			aux_q <= aux_d;
			cnt_q <= cnt_d;
			ucnt_q <= ucnt_d;
			widx_q <= widx_d;
			pidx_q <= pidx_d;
			bvalid_q <= bvalid_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			flash_req <= req_d;
			cpu_stall <= stall_d;
		end
	end

	// Write buffer storage, no reset needed
	always_ff @(posedge pclk) begin
		if (buf_we) begin
			buf_q[widx_q] <= {pwdata[7:0], dlow_q};
		end
	end

endmodule : fiap_ctrl

/* File: core/fiap_pkg.sv */
// Package for the flash in-application access controller
package fiap_pkg;

	// APB register byte offsets
	localparam logic [7:0] FIAP_CTRL_OFS = 8'h00;
	localparam logic [7:0] FIAP_ADDR_LOW_OFS = 8'h04;
	localparam logic [7:0] FIAP_ADDR_HIGH_OFS = 8'h08;
	localparam logic [7:0] FIAP_DATA_LOW_OFS = 8'h0c;
	localparam logic [7:0] FIAP_DATA_HIGH_OFS = 8'h10;
	localparam logic [7:0] FIAP_AUX_LOW_OFS = 8'h14;
	localparam logic [7:0] FIAP_AUX_HIGH_OFS = 8'h18;
	localparam logic [7:0] FIAP_STATUS_OFS = 8'h1c;

	// Control register bit positions
	localparam int FIAP_MODE_LSB = 0;
	localparam int FIAP_READ_EN_POS = 4;
	localparam int FIAP_READ_REQ_POS = 5;
	localparam int FIAP_TRIG_POS = 6;
	localparam int FIAP_ARM_POS = 7;
	localparam int FIAP_UNLOCK_POS = 8;
	localparam int FIAP_CLR_BUF_POS = 9;
	localparam int FIAP_TSEL_POS = 10;

	// Status register bit positions
	localparam int FIAP_STALL_POS = 0;
	localparam int FIAP_REFUSED_POS = 1;

	// Operation mode codes
	localparam logic [2:0] FIAP_MODE_PROG = 3'h0;
	localparam logic [2:0] FIAP_MODE_ERASE = 3'h1;
	localparam logic [2:0] FIAP_MODE_READ = 3'h3;
	localparam logic [2:0] FIAP_MODE_UNLOCK = 3'h6;

	// Page geometry: 32 words, page number from address bits 11..5
	localparam int FIAP_PAGE_WORDS = 32;
	localparam int FIAP_WIDX_W = 5;
	localparam int FIAP_PAGE_W = 7;
	localparam int FIAP_ADDR_W = 12;

	// Unlock pattern, low bytes 1..3 then high bytes 1..3
	localparam logic [47:0] FIAP_UNLOCK_PAT = 48'h00_0d_c3_04_09_40;

	// Timing, 100 MHz clock
	localparam int FIAP_CLK_NS = 10;
	localparam int FIAP_READ_CYC = 3;
	localparam int FIAP_CNT_W = 20;
	localparam int FIAP_UNLOCK_US = 10;
	localparam int FIAP_UNLOCK_CYC = FIAP_UNLOCK_US * 1000 / FIAP_CLK_NS;
	localparam int FIAP_OP_SHORT_US = 2000;
	localparam int FIAP_OP_LONG_US = 4000;

	// Flash array side request carrier
	typedef struct packed {
		logic rd;
		logic erase;
		logic prog;
		logic [FIAP_ADDR_W-1:0] addr;
		logic [15:0] wdata;
	} fiap_flash_req_t;

endpackage : fiap_pkg

/* File: test/fiap_checker.sv */
// Assertion checker for the flash access controller ports
`timescale 1ns/1ns
module fiap_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire fiap_pkg::fiap_flash_req_t flash_req,
	input wire logic cpu_stall
);
	import fiap_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rd_busy;
		cpu_stall [*2] ##[1:3] !cpu_stall;
	endsequence
	property p_rd_time;
		flash_req.rd |-> s_rd_busy;
	endproperty
	a_rd_time: assert property (p_rd_time) else $error("read stall length");
	property p_rd_pulse;
		flash_req.rd |=> !flash_req.rd;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe");
	property p_er_pulse;
		flash_req.erase |=> !flash_req.erase;
	endproperty
	a_er_pulse: assert property (p_er_pulse) else $error("erase strobe");
	property p_er_stall;
		flash_req.erase || flash_req.prog |-> cpu_stall;
	endproperty
	a_er_stall: assert property (p_er_stall) else $error("no stall");
	property p_excl;
		flash_req.rd |-> !flash_req.erase && !flash_req.prog;
	endproperty
	a_excl: assert property (p_excl) else $error("mixed requests");
	property p_rdy_pulse;
		pready |=> !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
	property p_rdy_phase;
		pready |-> psel && penable && $past(!cpu_stall);
	endproperty
	a_rdy_phase: assert property (p_rdy_phase) else $error("ready outside access");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_rdata;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data not zero");
endmodule : fiap_checker

bind fiap_ctrl fiap_checker i_fiap_checker (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .flash_req(flash_req), .cpu_stall(cpu_stall));

/* File: test/fiap_flash_model.sv */
// Behavioural model of the flash program memory array
`timescale 1ns/1ns
module fiap_flash_model (
	input wire logic pclk,
	input wire fiap_pkg::fiap_flash_req_t flash_req,
	output logic [15:0] flash_rdata
);
	import fiap_pkg::*;
	logic [15:0] mem [0:4095];
	logic [11:0] rd_addr_q = 12'h000;
	logic [2:0] hold_q = 3'h0;
	int prog_cnt = 0;
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 16'ha000 | 16'(i);
		end
	end
	// Word valid shortly after a fetch, inverted otherwise
	assign flash_rdata = (hold_q != 3'h0) ? mem[rd_addr_q] : ~mem[rd_addr_q];
	always @(posedge pclk) begin
		if (flash_req.rd) begin
			rd_addr_q <= flash_req.addr;
			hold_q <= 3'h5;
		end else if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
		end
		if (flash_req.erase) begin
			for (int i = 0; i < FIAP_PAGE_WORDS; i++) begin
				mem[{flash_req.addr[11:5], 5'(i)}] <= 16'hffff;
			end
		end
		if (flash_req.prog) begin
			mem[flash_req.addr] <= flash_req.wdata;
			prog_cnt <= prog_cnt + 1;
		end
	end
endmodule : fiap_flash_model

/* File: test/tb_fiap_ctrl.sv */
// Self-checking testbench for the flash access controller
`timescale 1ns/1ns
module tb_fiap_ctrl;
	import fiap_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, cpu_stall;
	logic [15:0] flash_rdata;
	fiap_flash_req_t flash_req;
	int miscompares = 0, check_count = 0;
	fiap_ctrl #(.OP_SHORT_CYC(20), .OP_LONG_CYC(40), .UNLOCK_CYC(50))
	i_fiap_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash_req(flash_req), .flash_rdata(flash_rdata),
		.cpu_stall(cpu_stall));
	fiap_flash_model i_fiap_flash_model (.pclk(pclk), .flash_req(flash_req),
		.flash_rdata(flash_rdata));
	initial begin
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic t_reset;
		apb(1'b0, FIAP_CTRL_OFS, 32'h0);
		chk("ctrl", rv, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", {31'h0, e}, 32'h1);
		$display("reset test done");
	endtask : t_reset
	task automatic t_read;
		wr(FIAP_ADDR_LOW_OFS, 32'h23);
		wr(FIAP_ADDR_HIGH_OFS, 32'h1);
		wr(FIAP_CTRL_OFS, 32'h23);
		apb(1'b0, FIAP_CTRL_OFS, 32'h0);
		chk("rreq_refused", rv & 32'h20, 32'h0);
		wr(FIAP_CTRL_OFS, 32'h33);
		chk("read_stall", {31'h0, cpu_stall}, 32'h1);
		apb(1'b0, FIAP_DATA_LOW_OFS, 32'h0);
		chk("data_low", rv, 32'h23);
		apb(1'b0, FIAP_DATA_HIGH_OFS, 32'h0);
		chk("data_high", rv, 32'ha1);
		apb(1'b0, FIAP_CTRL_OFS, 32'h0);
		chk("rreq_clear", rv & 32'h20, 32'h0);
		$display("read test done");
	endtask : t_read
	task automatic t_lock;
		wr(FIAP_CTRL_OFS, 32'h41);
		apb(1'b0, FIAP_STATUS_OFS, 32'h0);
		chk("refused", rv & 32'h2, 32'h2);
		chk("no_erase", 32'(i_fiap_flash_model.mem[12'h120]), 32'ha120);
		wr(FIAP_CTRL_OFS, 32'h06);
		wr(FIAP_CTRL_OFS, 32'h86);
		wr(FIAP_AUX_LOW_OFS, 32'h000dc3);
		wr(FIAP_AUX_HIGH_OFS, 32'h040940);
		apb(1'b0, FIAP_CTRL_OFS, 32'h0);
		chk("armed", rv & 32'h80, 32'h80);
		repeat (60) @(posedge pclk);
		apb(1'b0, FIAP_CTRL_OFS, 32'h0);
		chk("unlocked", rv & 32'h100, 32'h100);
		chk("arm_timeout", rv & 32'h80, 32'h0);
		$display("unlock test done");
	endtask : t_lock
	task automatic t_prog;
		wr(FIAP_ADDR_LOW_OFS, 32'ha0);
		wr(FIAP_ADDR_HIGH_OFS, 32'h0);
		wr(FIAP_CTRL_OFS, 32'h341);
		apb(1'b0, FIAP_STATUS_OFS, 32'h0);
		chk("erase_last", 32'(i_fiap_flash_model.mem[12'h0bf]), 32'hffff);
		chk("next_page", 32'(i_fiap_flash_model.mem[12'h0c0]), 32'ha0c0);
		wr(FIAP_CTRL_OFS, 32'h100);
		wr(FIAP_DATA_LOW_OFS, 32'h34);
		wr(FIAP_DATA_HIGH_OFS, 32'h12);
		wr(FIAP_DATA_LOW_OFS, 32'h78);
		wr(FIAP_DATA_HIGH_OFS, 32'h56);
		wr(FIAP_CTRL_OFS, 32'h140);
		apb(1'b0, FIAP_STATUS_OFS, 32'h0);
		chk("word0", 32'(i_fiap_flash_model.mem[12'h0a0]), 32'h1234);
		chk("word1", 32'(i_fiap_flash_model.mem[12'h0a1]), 32'h5678);
		chk("prog_n", i_fiap_flash_model.prog_cnt, 32'h2);
		// Buffer cleared and one word reloaded, same page, no erase
		wr(FIAP_CTRL_OFS, 32'h300);
		wr(FIAP_ADDR_LOW_OFS, 32'ha0);
		wr(FIAP_DATA_LOW_OFS, 32'h34);
		wr(FIAP_DATA_HIGH_OFS, 32'h12);
		// Long operation time selected for the repeat
		wr(FIAP_CTRL_OFS, 32'h540);
		repeat (25) @(posedge pclk);
		chk("long_busy", {31'h0, cpu_stall}, 32'h1);
		repeat (20) @(posedge pclk);
		chk("long_done", {31'h0, cpu_stall}, 32'h0);
		apb(1'b0, FIAP_STATUS_OFS, 32'h0);
		chk("reprog_n", i_fiap_flash_model.prog_cnt, 32'h3);
		$display("program test done");
	endtask : t_prog
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#300000;
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_read();
		t_lock();
		t_prog();
		give_verdict();
	end
endmodule : tb_fiap_ctrl
